// ### dv/pfw_ctrl_asserts.sv
`timescale 1ns/10ps
// port-level checks of the sequencer
module pfw_ctrl_asserts
   import pfw_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // cpu port and configuration pins
   input wire logic reg_wr,
   input wire logic [2:0] reg_sel,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic code_protect_bit,
   input wire logic ext_serial_programming_port,
   // watched outputs
   input wire logic cpu_skip,
   input wire logic cpu_stall,
   input wire logic flash_rd,
   input wire logic flash_test_space,
   input wire logic [ADDR_W-1:0] flash_addr,
   input wire logic flash_erase,
   input wire logic flash_prog,
   input wire logic powerup_busy,
   input wire logic test_access_en,
   input wire logic ext_prog_write_en
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // read trigger while idle
   sequence s_rd_trig;
      reg_wr && reg_sel == SEL_CONTROL && reg_wdata[0] && !reg_wdata[1] && !cpu_stall
      && !cpu_skip && !powerup_busy;
   endsequence
   // eight word cycles then release
   sequence s_burst;
      flash_prog [*8] ##1 !flash_prog;
   endsequence
   read_skip_a: assert property (s_rd_trig |=> cpu_skip && flash_rd)
      else $error("no skipped cycle after read");
   skip_single_a: assert property (cpu_skip |=> !cpu_skip)
      else $error("skip too long");
   rd_with_skip_a: assert property (flash_rd == cpu_skip)
      else $error("array read off skip");
   prog_burst_a: assert property ($rose(flash_prog) |-> s_burst)
      else $error("program burst not eight");
   prog_stalls_a: assert property (flash_prog || flash_erase |-> cpu_stall)
      else $error("array busy without stall");
   powerup_lock_a: assert property (powerup_busy |-> !flash_prog && !cpu_stall)
      else $error("write during power-up");
   erase_row_a: assert property (flash_erase |-> flash_addr[3:0] == ERASE_ROW_LOW)
      else $error("erase off row point");
   cal_no_write_a: assert property (flash_test_space |-> !flash_prog)
      else $error("write in test space");
   unlock_zero_a: assert property ($past(rst_n) && $past(reg_sel) == SEL_UNLOCK |->
      reg_rdata == 8'h00) else $error("unlock port not zero");
   test_access_a: assert property ($past(rst_n) |->
      test_access_en == !$past(code_protect_bit)) else $error("test access wrong");
   ext_write_a: assert property ($past(rst_n) |->
      ext_prog_write_en == ($past(ext_serial_programming_port) && !$past(code_protect_bit)))
      else $error("external write gate wrong");
endmodule : pfw_ctrl_asserts
bind pfw_ctrl pfw_ctrl_asserts u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr),
   .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .code_protect_bit(code_protect_bit), .cpu_skip(cpu_skip), .cpu_stall(cpu_stall),
   .flash_rd(flash_rd), .flash_test_space(flash_test_space), .flash_addr(flash_addr),
   .flash_erase(flash_erase), .flash_prog(flash_prog), .powerup_busy(powerup_busy),
   .test_access_en(test_access_en), .ext_serial_programming_port(ext_serial_programming_port),
   .ext_prog_write_en(ext_prog_write_en));

// ### dv/pfw_flash_model.sv
`timescale 1ns/10ps
// behavioural program array behind the sequencer
module pfw_flash_model
   import pfw_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // array port
   input wire logic flash_rd,
   input wire logic flash_test_space,
   input wire logic [ADDR_W-1:0] flash_addr,
   output logic [DATA_W-1:0] flash_rdata,
   input wire logic flash_erase,
   input wire logic flash_prog,
   input wire logic [DATA_W-1:0] flash_wdata,
   input wire logic [2:0] flash_word
);
   logic [DATA_W-1:0] mem [0:8191];
   // seeded contents
   initial
   begin
      for (int i = 0; i < 8192; i++)
         mem[i] = DATA_W'(i) ^ 14'h2a5a;
   end
   // valid only while the read strobe stands, inverted otherwise
   assign flash_rdata = !flash_rd ? ~mem[flash_addr] :
      flash_test_space ? mem[flash_addr] ^ 14'h1234 : mem[flash_addr];
   // row erase and per-word programming
   always @(posedge sys_clk)
   begin
      if (flash_erase)
         for (int i = 0; i < 16; i++)
            mem[{flash_addr[12:4], 4'h0} + i] <= 14'h3fff;
      if (flash_prog)
         mem[{flash_addr[12:3], flash_word}] <= flash_wdata;
   end
endmodule : pfw_flash_model

// ### dv/tb_pfw_ctrl.sv
`timescale 1ns/10ps
// self-checking bench for the flash self-write sequencer
module tb_pfw_ctrl
   import pfw_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [2:0] reg_sel = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [1:0] write_protect_field = 2'h3;
   logic code_protect_bit = 1'b0;
   logic ext_serial_programming_port = 1'b0;
   logic [7:0] reg_rdata;
   logic cpu_skip, cpu_stall, flash_rd, flash_test_space, flash_erase, flash_prog;
   logic powerup_busy;
   logic [ADDR_W-1:0] flash_addr;
   logic [DATA_W-1:0] flash_rdata, flash_wdata;
   logic [2:0] flash_word;
   logic [7:0] exp_q [$];
   logic rd_seen = 1'b0;
   logic [13:0] dat [0:7];
   logic [12:0] ra;
   int seed = 51955;
   int n_errors = 0;
   int compares = 0;
   int cyc = 0;
   always #20 sys_clk = ~sys_clk;
   pfw_ctrl #(.ERASE_COUNT(20), .PWRUP_COUNT(50)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .write_protect_field(write_protect_field),
      .code_protect_bit(code_protect_bit),
      .ext_serial_programming_port(ext_serial_programming_port), .cpu_skip(cpu_skip),
      .cpu_stall(cpu_stall), .flash_rd(flash_rd), .flash_test_space(flash_test_space),
      .flash_addr(flash_addr), .flash_rdata(flash_rdata), .flash_erase(flash_erase),
      .flash_prog(flash_prog), .flash_wdata(flash_wdata), .flash_word(flash_word),
      .powerup_busy(powerup_busy), .test_access_en(), .ext_prog_write_en());
   pfw_flash_model u_flash (.sys_clk(sys_clk), .flash_rd(flash_rd),
      .flash_test_space(flash_test_space), .flash_addr(flash_addr), .flash_rdata(flash_rdata),
      .flash_erase(flash_erase), .flash_prog(flash_prog), .flash_wdata(flash_wdata),
      .flash_word(flash_word));
   task automatic cmp(input logic [13:0] got, input logic [13:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic chk(input logic got, input logic exp);
      cmp({13'h0, got}, {13'h0, exp});
   endtask : chk
   task automatic conclude();
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude
   // oldest noted byte against each read result
   always @(posedge sys_clk)
   begin
      rd_seen <= reg_rd;
      if (rd_seen)
         cmp({6'h00, reg_rdata}, {6'h00, exp_q.pop_front()});
   end
   // hang guard and wandering configuration pins
   always @(posedge sys_clk)
   begin
      cyc++;
      code_protect_bit <= 1'($random(seed));
      ext_serial_programming_port <= 1'($random(seed));
      if (cyc == 20000)
      begin
         n_errors++;
         conclude();
      end
   end
   task automatic wr(input logic [2:0] sel, input logic [7:0] d);
      reg_wr <= 1'b1;
      reg_sel <= sel;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask : wr
   task automatic rd(input logic [2:0] sel, input logic [7:0] e);
      exp_q.push_back(e);
      reg_rd <= 1'b1;
      reg_sel <= sel;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
   endtask : rd
   task automatic rword(input logic [12:0] a, input logic [13:0] e, input logic [7:0] ctl);
      wr(SEL_ADDR_LOW, a[7:0]);
      wr(SEL_ADDR_HIGH, {3'h0, a[12:8]});
      wr(SEL_CONTROL, ctl);
      chk(cpu_skip, 1'b1);
      rd(SEL_DATA_LOW, e[7:0]);
      rd(SEL_DATA_HIGH, {2'h0, e[13:8]});
   endtask : rword
   task automatic wword(input logic [12:0] a, input logic [13:0] d, input logic [7:0] k2,
      input logic stall);
      wr(SEL_ADDR_LOW, a[7:0]);
      wr(SEL_ADDR_HIGH, {3'h0, a[12:8]});
      wr(SEL_DATA_LOW, d[7:0]);
      wr(SEL_DATA_HIGH, {2'h0, d[13:8]});
      wr(SEL_UNLOCK, UNLOCK_KEY_1);
      wr(SEL_UNLOCK, k2);
      wr(SEL_CONTROL, 8'h06);
      @(posedge sys_clk);
      chk(cpu_stall, stall);
      for (int n = 0; n < 100 && cpu_stall; n++)
         @(posedge sys_clk);
      repeat (4) @(posedge sys_clk);
   endtask : wword
   task automatic wblock(input logic [12:0] b, input logic [7:0] k2, input logic ok);
      for (int i = 0; i < 8; i++)
         wword(b + 13'(i), dat[i], k2, ok && i == 7);
      for (int i = 0; i < 8; i++)
         cmp(u_flash.mem[b + 13'(i)], ok ? dat[i] : 14'(b + 13'(i)) ^ 14'h2a5a);
   endtask : wblock
   // main sequence
   initial
   begin
      for (int i = 0; i < 8; i++)
         dat[i] = 14'($random(seed));
      ra = 13'($random(seed));
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      chk(powerup_busy, 1'b1);
      rd(SEL_CONTROL, CONTROL_RESET);
      rd(SEL_UNLOCK, 8'h00);
      wword(13'h1f07, dat[0], UNLOCK_KEY_2, 1'b0);
      for (int n = 0; n < 100 && powerup_busy; n++)
         @(posedge sys_clk);
      chk(powerup_busy, 1'b0);
      wr(SEL_CONTROL, 8'h04);
      rword(ra, 14'(ra) ^ 14'h2a5a, 8'h05);
      rword(ra, 14'(ra) ^ 14'h2a5a ^ 14'h1234, 8'h45);
      rword(ra, 14'(ra) ^ 14'h2a5a, 8'h05);
      write_protect_field <= 2'h1;
      wblock(13'h1f08, UNLOCK_KEY_2, 1'b1);
      for (int i = 1; i < 8; i++)
         rword(13'h1f08 + 13'(i), dat[i], 8'h05);
      dat[0] = 14'($random(seed));
      wblock(13'h1f08, UNLOCK_KEY_2, 1'b1);
      wblock(13'h0208, UNLOCK_KEY_2, 1'b0);
      wblock(13'h1f10, 8'h5a, 1'b0);
      write_protect_field <= 2'h2;
      wblock(13'h0208, UNLOCK_KEY_2, 1'b1);
      rd(SEL_CONTROL, 8'h84);
      conclude();
   end
endmodule : tb_pfw_ctrl

// ### rtl/pfw_ctrl.sv
`timescale 1ns/10ps
module pfw_ctrl
   import pfw_pkg::*;
#(
   parameter int ERASE_COUNT = ERASE_CYCLES,
   parameter int PWRUP_COUNT = PWRUP_CYCLES
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // cpu register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [2:0] reg_sel,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // configuration
   input wire logic [1:0] write_protect_field,
   input wire logic code_protect_bit,
   input wire logic ext_serial_programming_port,
   // cpu pipeline control
   output logic cpu_skip,
   output logic cpu_stall,
   // flash array
   output logic flash_rd,
   output logic flash_test_space,
   output logic [ADDR_W-1:0] flash_addr,
   input wire logic [DATA_W-1:0] flash_rdata,
   output logic flash_erase,
   output logic flash_prog,
   output logic [DATA_W-1:0] flash_wdata,
   output logic [2:0] flash_word,
   // status and external programming
   output logic powerup_busy,
   output logic test_access_en,
   output logic ext_prog_write_en
);
   logic [7:0] flash_addr_low;
   logic [4:0] flash_addr_high;
   logic [7:0] flash_data_low;
   logic [5:0] flash_data_high;
   logic write_permit;
   logic cal_space_select;
   logic read_trig;
   logic write_trig;
   logic [1:0] unlock_step;
   logic [DATA_W-1:0] buffer [BLOCK_WORDS];
   pfw_state_e state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] pwr_cnt;
   logic [2:0] prog_idx;
   logic do_erase;
   logic writable;
   logic [ADDR_W-1:0] cur_addr;
   logic [ADDR_W-1:0] block_base;
   logic write_req;
   logic write_ok;

   assign cur_addr = {flash_addr_high[4:0], flash_addr_low};
   assign block_base = {cur_addr[ADDR_W-1:3], 3'h0};

   pfw_protect_check u_protect (.word_addr(cur_addr),
      .write_protect_field(write_protect_field), .writable(writable));

   // write trigger accepted only directly after unlock
   assign write_req = reg_wr && reg_sel == SEL_CONTROL && reg_wdata[CTL_WRITE_BIT]
      && state == PFW_IDLE && !write_trig;
   assign write_ok = write_req && unlock_step == 2'h2
      && write_permit && reg_wdata[CTL_PERMIT_BIT]
      && !powerup_busy
      && !cal_space_select && !reg_wdata[CTL_CAL_BIT]
      && writable;

   // power-up timer
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         pwr_cnt <= '0;
         powerup_busy <= 1'b1;
      end
      else if (powerup_busy)
      begin
         pwr_cnt <= pwr_cnt + 1'b1;
         if (pwr_cnt == CNT_W'(PWRUP_COUNT - 1))
            powerup_busy <= 1'b0;
      end
   end

   // unlock sequence tracker, any other access breaks it
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         unlock_step <= 2'h0;
      else if (reg_wr && reg_sel == SEL_UNLOCK)
      begin
         if (reg_wdata == UNLOCK_KEY_1)
            unlock_step <= 2'h1;
         else if (reg_wdata == UNLOCK_KEY_2 && unlock_step == 2'h1)
            unlock_step <= 2'h2;
         else
            unlock_step <= 2'h0;
      end
      else if (reg_wr || reg_rd)
         unlock_step <= 2'h0;
   end

   // address registers
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         flash_addr_low <= 8'h00;
         flash_addr_high <= 5'h00;
      end
      else if (reg_wr && state == PFW_IDLE)
      begin
         if (reg_sel == SEL_ADDR_LOW)
            flash_addr_low <= reg_wdata;
         if (reg_sel == SEL_ADDR_HIGH)
            flash_addr_high <= reg_wdata[4:0];
      end
   end

   // data registers, loaded from flash after read
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         flash_data_low <= 8'h00;
         flash_data_high <= 6'h00;
      end
      else if (state == PFW_READ_WAIT)
      begin
         flash_data_low <= flash_rdata[7:0];
         flash_data_high <= flash_rdata[13:8];
      end
      else if (reg_wr && reg_sel == SEL_DATA_LOW)
         flash_data_low <= reg_wdata;
      else if (reg_wr && reg_sel == SEL_DATA_HIGH)
         flash_data_high <= reg_wdata[5:0];
   end

   // control bits, triggers set-only by software
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         write_permit <= 1'b0;
         cal_space_select <= 1'b0;
         read_trig <= 1'b0;
         write_trig <= 1'b0;
      end
      else
      begin
         if (reg_wr && reg_sel == SEL_CONTROL)
         begin
            write_permit <= reg_wdata[CTL_PERMIT_BIT];
            cal_space_select <= reg_wdata[CTL_CAL_BIT];
         end
         if (reg_wr && reg_sel == SEL_CONTROL && reg_wdata[CTL_READ_BIT]
            && state == PFW_IDLE)
            read_trig <= 1'b1;
         else if (state == PFW_READ_WAIT)
            read_trig <= 1'b0;
         if (write_ok)
            write_trig <= 1'b1;
         else if (state == PFW_RESUME)
            write_trig <= 1'b0;
      end
   end

   // word buffer loaded on every accepted write
   always_ff @(posedge sys_clk)
   begin
      if (write_ok)
         buffer[cur_addr[2:0]] <= {flash_data_high, flash_data_low};
   end

   // sequencer: read skip, setup, erase stall, program, resume
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         state <= PFW_IDLE;
         cnt <= '0;
         prog_idx <= 3'h0;
         do_erase <= 1'b0;
      end
      else
      begin
         case (state)
            PFW_IDLE:
            begin
               cnt <= '0;
               prog_idx <= 3'h0;
               if (reg_wr && reg_sel == SEL_CONTROL && reg_wdata[CTL_READ_BIT])
                  state <= PFW_READ_WAIT;
               else if (write_ok)
               begin
                  do_erase <= cur_addr[3:0] == ERASE_ROW_LOW;
                  state <= PFW_SETUP;
               end
            end
            PFW_READ_WAIT:
               state <= PFW_IDLE;
            PFW_SETUP:
            begin
               cnt <= cnt + 1'b1;
               if (cnt == CNT_W'(SETUP_CYCLES - 1))
               begin
                  cnt <= '0;
                  if (cur_addr[2:0] != LAST_WORD_LOW)
                     state <= PFW_RESUME;
                  else if (do_erase)
                     state <= PFW_ERASE;
                  else
                     state <= PFW_PROGRAM;
               end
            end
            PFW_ERASE:
            begin
               cnt <= cnt + 1'b1;
               if (cnt == CNT_W'(ERASE_COUNT - 1))
               begin
                  cnt <= '0;
                  state <= PFW_PROGRAM;
               end
            end
            PFW_PROGRAM:
            begin
               prog_idx <= prog_idx + 1'b1;
               if (prog_idx == 3'(BLOCK_WORDS - 1))
                  state <= PFW_RESUME;
            end
            PFW_RESUME:
               state <= PFW_IDLE;
            default:
               state <= PFW_IDLE;
         endcase
      end
   end

   // flash strobes and cpu control outputs
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         flash_rd <= 1'b0;
         flash_test_space <= 1'b0;
         flash_addr <= '0;
         flash_erase <= 1'b0;
         flash_prog <= 1'b0;
         flash_wdata <= '0;
         flash_word <= 3'h0;
         cpu_skip <= 1'b0;
         cpu_stall <= 1'b0;
      end
      else
      begin
         flash_rd <= reg_wr && reg_sel == SEL_CONTROL && reg_wdata[CTL_READ_BIT]
            && state == PFW_IDLE;
         flash_test_space <= (reg_wr && reg_sel == SEL_CONTROL) ? reg_wdata[CTL_CAL_BIT]
            : cal_space_select;
         flash_erase <= state == PFW_SETUP && cnt == CNT_W'(SETUP_CYCLES - 1)
            && do_erase && cur_addr[2:0] == LAST_WORD_LOW;
         flash_prog <= state == PFW_PROGRAM;
         flash_word <= prog_idx;
         flash_wdata <= buffer[prog_idx];
         flash_addr <= state == PFW_PROGRAM ? (block_base | ADDR_W'(prog_idx))
            : cur_addr;
         cpu_skip <= state == PFW_IDLE && reg_wr && reg_sel == SEL_CONTROL
            && reg_wdata[CTL_READ_BIT];
         cpu_stall <= state == PFW_ERASE || state == PFW_PROGRAM
            || (state == PFW_SETUP && cur_addr[2:0] == LAST_WORD_LOW);
      end
   end

   // register read mux, unlock reads zero
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         reg_rdata <= 8'h00;
      else
      begin
         case (reg_sel)
            SEL_ADDR_LOW: reg_rdata <= flash_addr_low;
            SEL_ADDR_HIGH: reg_rdata <= {3'h0, flash_addr_high};
            SEL_DATA_LOW: reg_rdata <= flash_data_low;
            SEL_DATA_HIGH: reg_rdata <= {2'h0, flash_data_high};
            SEL_CONTROL: reg_rdata <= {1'b1, cal_space_select, 3'h0, write_permit,
               write_trig, read_trig};
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // code protection gates external access only
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         test_access_en <= 1'b0;
         ext_prog_write_en <= 1'b0;
      end
      else
      begin
         test_access_en <= !code_protect_bit;
         ext_prog_write_en <= ext_serial_programming_port && !code_protect_bit;
      end
   end
endmodule : pfw_ctrl

// ### rtl/pfw_pkg.sv
package pfw_pkg;
   // register access selectors on the cpu-side port
   localparam logic [2:0] SEL_ADDR_LOW = 3'h0;
   localparam logic [2:0] SEL_ADDR_HIGH = 3'h1;
   localparam logic [2:0] SEL_DATA_LOW = 3'h2;
   localparam logic [2:0] SEL_DATA_HIGH = 3'h3;
   localparam logic [2:0] SEL_CONTROL = 3'h4;
   localparam logic [2:0] SEL_UNLOCK = 3'h5;
   // control register field positions
   localparam int CTL_READ_BIT = 0;
   localparam int CTL_WRITE_BIT = 1;
   localparam int CTL_PERMIT_BIT = 2;
   localparam int CTL_CAL_BIT = 6;
   localparam int CTL_ONE_BIT = 7;
   // widths
   localparam int ADDR_W = 13;
   localparam int DATA_W = 14;
   localparam int BLOCK_WORDS = 8;
   // unlock keys
   localparam logic [7:0] UNLOCK_KEY_1 = 8'h55;
   localparam logic [7:0] UNLOCK_KEY_2 = 8'haa;
   // block commit pattern on the low address bits
   localparam logic [2:0] LAST_WORD_LOW = 3'h7;
   localparam logic [3:0] ERASE_ROW_LOW = 4'h3;
   // timing
   localparam int CLK_HZ = 25000000;
   localparam int ERASE_TIME_US = 4000;
   localparam int PWRUP_TIME_US = 72000;
   localparam int ERASE_CYCLES = CLK_HZ / 1000000 * ERASE_TIME_US;
   localparam int PWRUP_CYCLES = CLK_HZ / 1000000 * PWRUP_TIME_US;
   localparam int SETUP_CYCLES = 2;
   localparam int CNT_W = 24;
   // reset values
   localparam logic [7:0] CONTROL_RESET = 8'h80;
   // sequencer states
   typedef enum logic [2:0] {
      PFW_IDLE,
      PFW_READ_WAIT,
      PFW_SETUP,
      PFW_ERASE,
      PFW_PROGRAM,
      PFW_RESUME
   } pfw_state_e;
endpackage : pfw_pkg

// ### rtl/pfw_protect_check.sv
`timescale 1ns/10ps
// decides whether a word address lies in a write-protected segment
module pfw_protect_check
   import pfw_pkg::*;
(
   // address and configuration
   input wire logic [ADDR_W-1:0] word_addr,
   input wire logic [1:0] write_protect_field,
   // result
   output logic writable
);
   // 11 none, 10 lowest 512 words, 01 lower half, 00 everything
   always_comb
   begin
      case (write_protect_field)
         2'h3: writable = 1'b1;
         2'h2: writable = (word_addr[12:9] != 4'h0);
         2'h1: writable = word_addr[12];
         default: writable = 1'b0;
      endcase
   end
endmodule : pfw_protect_check
